/* File: inc/smrc_defs.svh */
/*
 * Constants of the stop mode release controller: register offsets, field positions, reset values and
 * timing figures. Assumes a byte-addressed Avalon-MM slave with 32-bit data.
 */
`ifndef SMRC_DEFS_SVH
`define SMRC_DEFS_SVH

`define SMRC_ADDR_W 8
`define SMRC_OFS_PWR_CTRL 8'h00
`define SMRC_OFS_SETTLE_SEL 8'h04
`define SMRC_OFS_CLK_CFG 8'h08
`define SMRC_OFS_WAKE_MASK 8'h0c
`define SMRC_OFS_STATUS 8'h10

// Power save control: stop request bit
`define SMRC_PWR_STOP_BIT 0
// Settle select field width and reset value (2^19 cycles with the default base)
`define SMRC_SETTLE_SEL_W 3
`define SMRC_SETTLE_SEL_RST 3'h6
`define SMRC_SETTLE_EXP_BASE 13
// Peripheral clock source configuration fields
`define SMRC_CFG_TM0_WTI 0
`define SMRC_CFG_WT_SUB 1
`define SMRC_CFG_TM4_SUB 2
`define SMRC_CFG_TM5_SUB 3
`define SMRC_CFG_CSI_LSB 4
`define SMRC_CFG_UART_LSB 7
`define SMRC_CFG_RTO_TM5 9
`define SMRC_CFG_RTO_EN 10
`define SMRC_CFG_W 11
`define SMRC_CFG_RST 11'h000
// Peripheral index within the run and wake vectors
`define SMRC_P_TM0 0
`define SMRC_P_TM4 1
`define SMRC_P_TM5 2
`define SMRC_P_WT 3
`define SMRC_P_CSI 4
`define SMRC_P_UTX 7
`define SMRC_P_URX 9
`define SMRC_P_RTO 11
`define SMRC_NPER 12
`define SMRC_WAKE_MASK_RST 12'hfff
// Status fields
`define SMRC_ST_STATE_LSB 0
`define SMRC_ST_CAUSE_LSB 2
`define SMRC_ST_SUB 5
`define SMRC_ST_RUN_LSB 6

`endif

/* File: inc/smrc_pkg.sv */
/*
 * Types of the stop mode release controller: sequencer states and wake causes.
 * Assumes nothing beyond the constants header.
 */
package smrc_pkg;

   typedef enum logic [1:0] {
      SMRC_RUN = 2'b00,
      SMRC_STOP = 2'b01,
      SMRC_SETTLE = 2'b10,
      SMRC_RESUME = 2'b11
   } smrc_state_t;

   typedef enum logic [2:0] {
      SMRC_WK_NONE = 3'b000,
      SMRC_WK_NMI = 3'b001,
      SMRC_WK_EXT = 3'b010,
      SMRC_WK_PERIPH = 3'b011
   } smrc_wake_t;

endpackage : smrc_pkg

/* File: hdl/smrc_sync3.sv */
/*
 * Three-stage input synchroniser with agreement filter for pins.
 * Assumes inputs are asynchronous to mclk_i; output changes once stages two and three agree.
 */
`timescale 1ns/1ps
module smrc_sync3 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Pins
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] lvl_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Per bit: a level counts only once two stages agree, which drops single-cycle glitches
   for (genvar i = 0; i < W; i++) begin : g_flt
      always_ff @(posedge mclk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            lvl_o[i] <= 1'b0;
         end else if (s2_q[i] == s3_q[i]) begin
            lvl_o[i] <= s3_q[i];
         end
      end
   end
endmodule : smrc_sync3

/* File: hdl/smrc_settle_cnt.sv */
/*
 * Oscillator settling counter, standing in for the watchdog counter during wake-up.
 * Assumes start is a one-cycle pulse; done pulses once 2^(base+sel) cycles after start.
 */
`timescale 1ns/1ps
module smrc_settle_cnt #(
   parameter int EXP_BASE = 13,
   parameter int SEL_W = 3
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Control
   input wire logic start_i,
   input wire logic [SEL_W-1:0] sel_i,
   output logic busy_o,
   output logic done_o
);
   localparam int CW = EXP_BASE + (1 << SEL_W);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] limit;
   logic [CW-1:0] one_w;

   assign one_w = CW'(1);
   assign limit = (one_w << (EXP_BASE + int'(sel_i))) - one_w;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            cnt_q <= '0;
            busy_o <= 1'b1;
         end else if (busy_o) begin
            if (cnt_q == limit) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end else begin
               cnt_q <= cnt_q + one_w;
            end
         end
      end
   end
endmodule : smrc_settle_cnt

/* File: hdl/smrc_ctrl.sv */
/*
 * Stop mode release controller: stop entry, wake detection, settling and clock restart, and the
 * peripheral run gating while stopped, with its registers on an Avalon-MM slave.
 * Assumes one 200 MHz clock; pins arrive asynchronously; peripheral irqs are on mclk_i.
 */
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "smrc_defs.svh"
module smrc_ctrl
   import smrc_pkg::*;
#(
   parameter int SETTLE_EXP_BASE = `SMRC_SETTLE_EXP_BASE
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Avalon-MM slave
   input wire logic [`SMRC_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // CPU side
   input wire logic cpu_on_main_i,
   output logic cpu_clk_en_o,
   output logic wake_vector_o,
   output logic [2:0] wake_src_o,
   // Clock generator
   input wire logic subclock_present_i,
   output logic main_osc_en_o,
   output logic periph_clk_en_o,
   output logic sub_osc_en_o,
   // Peripherals
   input wire logic [`SMRC_NPER-1:0] periph_irq_i,
   output logic [`SMRC_NPER-1:0] periph_run_o,
   // External pins
   input wire logic nmi_i,
   input wire logic [3:0] ext_irq_group_low_i,
   input wire logic [2:0] ext_irq_group_high_i,
   input wire logic bus_hold_request_i,
   output logic [2:0] ext_irq_group_high_o,
   output logic bus_hold_ack_o,
   output logic port_hold_o,
   output logic bus_float_o
);
   smrc_state_t state_q, state_d;
   logic [`SMRC_SETTLE_SEL_W-1:0] settle_sel_q;
   logic [`SMRC_CFG_W-1:0] cfg_q;
   logic [`SMRC_NPER-1:0] wake_mask_q;
   logic [2:0] cause_q;
   logic sub_q;
   logic strap_done_q;

   // Pin synchronisation
   logic [8:0] pins_lvl;
   logic [8:0] pins_prev_q;
   logic nmi_rise;
   logic [3:0] ext_low_rise;

   smrc_sync3 #(
      .W(9)
   ) u_sync (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .pin_i({bus_hold_request_i, ext_irq_group_high_i, ext_irq_group_low_i, nmi_i}),
      .lvl_o(pins_lvl)
   );

   assign nmi_rise = pins_lvl[0] & ~pins_prev_q[0];
   assign ext_low_rise = pins_lvl[4:1] & ~pins_prev_q[4:1];

   // Bus decode
   logic req;
   logic acc;
   logic wr_acc;
   logic hit_pwr, hit_sel, hit_cfg, hit_mask, hit_st;
   logic [31:0] rd_mux;
   logic [31:0] status_w;

   assign req = avs_read_i | avs_write_i;
   assign acc = req & ~avs_waitrequest_o;
   assign wr_acc = acc & avs_write_i;
   assign hit_pwr = avs_address_i == `SMRC_OFS_PWR_CTRL;
   assign hit_sel = avs_address_i == `SMRC_OFS_SETTLE_SEL;
   assign hit_cfg = avs_address_i == `SMRC_OFS_CLK_CFG;
   assign hit_mask = avs_address_i == `SMRC_OFS_WAKE_MASK;
   assign hit_st = avs_address_i == `SMRC_OFS_STATUS;

   // Stop bit reads back as one from entry until the sequencer returns to run
   logic stop_flag;
   assign stop_flag = state_q != SMRC_RUN;

   // Peripheral run gating while stopped
   logic [`SMRC_NPER-1:0] run_stop;
   logic tm4_run, tm5_run;

   assign tm4_run = sub_q & cfg_q[`SMRC_CFG_TM4_SUB];
   assign tm5_run = sub_q & cfg_q[`SMRC_CFG_TM5_SUB];
   assign run_stop[`SMRC_P_TM0] = sub_q & cfg_q[`SMRC_CFG_TM0_WTI] & cfg_q[`SMRC_CFG_WT_SUB];
   assign run_stop[`SMRC_P_TM4] = tm4_run;
   assign run_stop[`SMRC_P_TM5] = tm5_run;
   assign run_stop[`SMRC_P_WT] = sub_q & cfg_q[`SMRC_CFG_WT_SUB];
   assign run_stop[`SMRC_P_CSI +: 3] = cfg_q[`SMRC_CFG_CSI_LSB +: 3];
   assign run_stop[`SMRC_P_UTX +: 2] = cfg_q[`SMRC_CFG_UART_LSB +: 2];
   assign run_stop[`SMRC_P_URX +: 2] = 2'h0;
   assign run_stop[`SMRC_P_RTO] = sub_q & cfg_q[`SMRC_CFG_RTO_EN]
      & (cfg_q[`SMRC_CFG_RTO_TM5] ? tm5_run : tm4_run);

   // Wake sources: only irqs of peripherals that can still run count
   logic periph_wake;
   logic ext_wake;
   logic any_wake;

   assign periph_wake = |(periph_irq_i & ~wake_mask_q & run_stop);
   assign ext_wake = |ext_low_rise;
   assign any_wake = nmi_rise | ext_wake | periph_wake;

   // Settling counter
   logic settle_start;
   logic settle_done;
   logic settle_busy;

   assign settle_start = (state_q == SMRC_STOP) & any_wake;

   smrc_settle_cnt #(
      .EXP_BASE(SETTLE_EXP_BASE),
      .SEL_W(`SMRC_SETTLE_SEL_W)
   ) u_settle (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .start_i(settle_start),
      .sel_i(settle_sel_q),
      .busy_o(settle_busy),
      .done_o(settle_done)
   );

   // Stop entry is honoured only while the CPU runs from the main clock
   logic stop_req;
   assign stop_req = wr_acc & hit_pwr & avs_writedata_i[`SMRC_PWR_STOP_BIT] & cpu_on_main_i;

   always_comb begin
      state_d = state_q;
      case (state_q)
         SMRC_RUN: begin
            if (stop_req) begin
               state_d = SMRC_STOP;
            end
         end
         SMRC_STOP: begin
            if (settle_start) begin
               state_d = SMRC_SETTLE;
            end
         end
         SMRC_SETTLE: begin
            if (settle_done) begin
               state_d = SMRC_RESUME;
            end
         end
         SMRC_RESUME: begin
            state_d = SMRC_RUN;
         end
         default: begin
            state_d = SMRC_RUN;
         end
      endcase
   end

   // Wake cause, priority NMI over external pins over peripherals
   logic [2:0] cause_d;
   assign cause_d = nmi_rise ? SMRC_WK_NMI : (ext_wake ? SMRC_WK_EXT : SMRC_WK_PERIPH);

   assign status_w = {{(32 - `SMRC_ST_RUN_LSB - `SMRC_NPER){1'b0}}, periph_run_o, sub_q, cause_q, state_q};

   assign rd_mux = hit_pwr ? {31'h0, stop_flag}
      : hit_sel ? {{(32 - `SMRC_SETTLE_SEL_W){1'b0}}, settle_sel_q}
      : hit_cfg ? {{(32 - `SMRC_CFG_W){1'b0}}, cfg_q}
      : hit_mask ? {{(32 - `SMRC_NPER){1'b0}}, wake_mask_q}
      : hit_st ? status_w
      : 32'h0;

   // Next values of the clock and pin controls
   logic stopped_d;
   logic clocks_on_d;
   assign stopped_d = state_d == SMRC_STOP || state_d == SMRC_SETTLE;
   assign clocks_on_d = !stopped_d;

   // Bus slave: one wait cycle, then the access completes
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h0;
      end else begin
         avs_waitrequest_o <= !(req && avs_waitrequest_o);
         if (req && avs_waitrequest_o) begin
            avs_readdata_o <= avs_read_i ? rd_mux : 32'h0;
         end
      end
   end

   // Software registers
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         settle_sel_q <= `SMRC_SETTLE_SEL_RST;
         cfg_q <= `SMRC_CFG_RST;
         wake_mask_q <= `SMRC_WAKE_MASK_RST;
      end else if (wr_acc) begin
         if (hit_sel) begin
            settle_sel_q <= avs_writedata_i[`SMRC_SETTLE_SEL_W-1:0];
         end
         if (hit_cfg) begin
            cfg_q <= avs_writedata_i[`SMRC_CFG_W-1:0];
         end
         if (hit_mask) begin
            wake_mask_q <= avs_writedata_i[`SMRC_NPER-1:0];
         end
      end
   end

   // Subclock strap is caught on the first edge after reset release
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sub_q <= 1'b0;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         sub_q <= subclock_present_i;
         strap_done_q <= 1'b1;
      end
   end

   // Sequencer and cause
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= SMRC_RUN;
         cause_q <= SMRC_WK_NONE;
         pins_prev_q <= 9'h000;
      end else begin
         state_q <= state_d;
         pins_prev_q <= pins_lvl;
         if (settle_start) begin
            cause_q <= cause_d;
         end
      end
   end

   // Clock, pin and vector outputs, all registered
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         main_osc_en_o <= 1'b1;
         cpu_clk_en_o <= 1'b1;
         periph_clk_en_o <= 1'b1;
         sub_osc_en_o <= 1'b1;
         periph_run_o <= {`SMRC_NPER{1'b1}};
         port_hold_o <= 1'b0;
         bus_float_o <= 1'b0;
         bus_hold_ack_o <= 1'b0;
         ext_irq_group_high_o <= 3'h0;
         wake_vector_o <= 1'b0;
         wake_src_o <= SMRC_WK_NONE;
      end else begin
         main_osc_en_o <= state_d != SMRC_STOP;
         cpu_clk_en_o <= clocks_on_d;
         periph_clk_en_o <= clocks_on_d;
         sub_osc_en_o <= 1'b1;
         periph_run_o <= stopped_d ? run_stop : {`SMRC_NPER{1'b1}};
         port_hold_o <= stopped_d;
         bus_float_o <= stopped_d;
         bus_hold_ack_o <= pins_lvl[8] & !stopped_d;
         ext_irq_group_high_o <= stopped_d ? 3'h0 : pins_lvl[7:5];
         // Clocks are already on in the resume cycle; the vector follows one cycle later
         wake_vector_o <= state_q == SMRC_RESUME;
         if (state_q == SMRC_RESUME) begin
            wake_src_o <= cause_q;
         end
      end
   end

   // Busy flag of the counter is only for status in a future revision
   logic unused_busy;
   assign unused_busy = settle_busy;

endmodule : smrc_ctrl

/* File: test/smrc_ctrl_assertions.sv */
/* Port checker of the stop mode release controller.
   Assumes it is bound onto smrc_ctrl and shares its SETTLE_EXP_BASE. */
`timescale 1ns/1ps
`include "smrc_defs.svh"
module smrc_ctrl_chk #(
   parameter int SETTLE_EXP_BASE = 2
) (
   // Clock, reset and bus
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [`SMRC_ADDR_W-1:0] avs_address_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic avs_waitrequest_o,
   // Control and status
   input wire logic cpu_on_main_i,
   input wire logic subclock_present_i,
   input wire logic cpu_clk_en_o,
   input wire logic wake_vector_o,
   input wire logic main_osc_en_o,
   input wire logic periph_clk_en_o,
   input wire logic sub_osc_en_o,
   input wire logic [`SMRC_NPER-1:0] periph_run_o,
   input wire logic [2:0] ext_irq_group_high_o,
   input wire logic bus_hold_ack_o,
   input wire logic port_hold_o,
   input wire logic bus_float_o
);
   logic [2:0] sel_q;
   logic [31:0] cnt_q;
   wire logic done_acc = avs_write_i && !avs_waitrequest_o;
   wire logic sel_wr = done_acc && avs_address_i == `SMRC_OFS_SETTLE_SEL;
   wire logic stop_wr = done_acc && avs_address_i == `SMRC_OFS_PWR_CTRL && avs_writedata_i[0] && !port_hold_o;
   wire logic [31:0] cnt_d = (!main_osc_en_o || cpu_clk_en_o) ? 32'h0 : cnt_q + 32'h1;
   wire logic [31:0] lim = 32'h1 << (SETTLE_EXP_BASE + sel_q);
   // Settle select is tracked from the bus, since only ports are visible
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sel_q <= `SMRC_SETTLE_SEL_RST;
         cnt_q <= 32'h0;
      end else begin
         if (sel_wr) sel_q <= avs_writedata_i[2:0];
         cnt_q <= cnt_d;
      end
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_vec;
      wake_vector_o ##1 !wake_vector_o;
   endsequence
   property p_settle_len;
      $rose(cpu_clk_en_o) |-> cnt_q >= lim && cnt_q <= lim + 32'h2;
   endproperty
   property p_vector;
      $rose(cpu_clk_en_o) |-> !wake_vector_o ##1 s_vec;
   endproperty
   property p_osc_wake;
      $rose(main_osc_en_o) |-> port_hold_o && !cpu_clk_en_o;
   endproperty
   property p_stop_off;
      port_hold_o && !main_osc_en_o |-> !periph_clk_en_o && sub_osc_en_o;
   endproperty
   property p_clk_held;
      port_hold_o |-> !cpu_clk_en_o && !periph_clk_en_o;
   endproperty
   property p_no_ack;
      port_hold_o |-> !bus_hold_ack_o;
   endproperty
   property p_pins;
      port_hold_o |-> bus_float_o && ext_irq_group_high_o == 3'h0;
   endproperty
   property p_no_sub;
      port_hold_o && !subclock_present_i |-> periph_run_o[3:0] == 4'h0 && !periph_run_o[11];
   endproperty
   property p_rx_off;
      port_hold_o |-> periph_run_o[10:9] == 2'h0;
   endproperty
   property p_run_all;
      !port_hold_o |-> periph_run_o == 12'hfff;
   endproperty
   property p_stop_entry;
      stop_wr && cpu_on_main_i |-> ##[1:2] (port_hold_o && !main_osc_en_o && !cpu_clk_en_o);
   endproperty
   property p_stop_refused;
      stop_wr && !cpu_on_main_i |-> ##1 !port_hold_o [*3];
   endproperty
   a_settle_len: assert property (p_settle_len) else $error("settle interval length wrong");
   a_vector: assert property (p_vector) else $error("no vector pulse after clock restart");
   a_osc_wake: assert property (p_osc_wake) else $error("oscillator restarted outside stop");
   a_stop_off: assert property (p_stop_off) else $error("clocks wrong while stopped");
   a_clk_held: assert property (p_clk_held) else $error("clock enabled before settling");
   a_no_ack: assert property (p_no_ack) else $error("hold acknowledged while stopped");
   a_pins: assert property (p_pins) else $error("pins wrong while stopped");
   a_no_sub: assert property (p_no_sub) else $error("timer runs without subclock");
   a_rx_off: assert property (p_rx_off) else $error("serial receive runs while stopped");
   a_run_all: assert property (p_run_all) else $error("peripheral gated while running");
   a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");
   a_stop_refused: assert property (p_stop_refused) else $error("stop entered off main clock");
endmodule : smrc_ctrl_chk

bind smrc_ctrl smrc_ctrl_chk #(.SETTLE_EXP_BASE(SETTLE_EXP_BASE)) smrc_ctrl_chk_inst (.*);

/* File: test/smrc_src_model.sv */
/* Interrupt sources and CPU vector acceptance seen from the controller.
   Assumes one-cycle fire requests from the bench on mclk_i. */
`timescale 1ns/1ps
module smrc_src_model (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Bench command: 0-11 peripheral, 12 nmi, 13 low group pin, 15 clear
   input wire logic fire_i,
   input wire logic [3:0] kind_i,
   input wire logic wake_vector_i,
   // Request lines
   output logic [11:0] irq_o,
   output logic nmi_o,
   output logic [3:0] ext_o
);
   // Requests stay up until the CPU vectors, as a real source would, or until the bench sends clear
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_o <= 12'h0;
         nmi_o <= 1'b0;
         ext_o <= 4'h0;
      end else if (wake_vector_i || (fire_i && kind_i == 4'hf)) begin
         irq_o <= 12'h0;
         nmi_o <= 1'b0;
         ext_o <= 4'h0;
      end else if (fire_i) begin
         if (kind_i < 4'hc) irq_o[kind_i] <= 1'b1;
         if (kind_i == 4'hc) nmi_o <= 1'b1;
         if (kind_i == 4'hd) ext_o[0] <= 1'b1;
      end
   end
endmodule : smrc_src_model

/* File: test/tb_smrc_ctrl.sv */
/* Bench of the stop mode release controller with its source model.
   Assumes a 200 MHz clock and a shortened settling base of 2. */
`timescale 1ns/1ps
`include "smrc_defs.svh"
module tb_smrc_ctrl
   import smrc_pkg::*;
;
   logic mclk_i = 0, nrst_i = 0, avs_read_i = 0, avs_write_i = 0, cpu_on_main_i = 1, subclock_present_i = 1;
   logic [7:0] avs_address_i = 0;
   logic [31:0] avs_writedata_i = 0, avs_readdata_o, q;
   logic avs_waitrequest_o, cpu_clk_en_o, wake_vector_o, main_osc_en_o, periph_clk_en_o, sub_osc_en_o;
   logic [2:0] wake_src_o, ext_irq_group_high_o, ext_irq_group_high_i = 0;
   logic [11:0] periph_irq_i, periph_run_o;
   logic nmi_i, bus_hold_request_i = 0, bus_hold_ack_o, port_hold_o, bus_float_o, fire = 0;
   logic [3:0] ext_irq_group_low_i, kind = 0;
   int fail_count = 0, num_checks = 0, cycles = 0;
   smrc_ctrl #(.SETTLE_EXP_BASE(2)) smrc_ctrl_inst (.*);
   smrc_src_model smrc_src_model_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .fire_i(fire), .kind_i(kind),
      .wake_vector_i(wake_vector_o), .irq_o(periph_irq_i), .nmi_o(nmi_i), .ext_o(ext_irq_group_low_i));
   initial begin
      forever #2.5 mclk_i = ~mclk_i;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results
   // Ceiling well above the two hundred or so cycles the tests need
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         results();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      avs_write_i <= wr;
      avs_read_i <= !wr;
      avs_address_i <= a;
      avs_writedata_i <= d;
      do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rd
   task automatic rst(input logic sub);
      @(posedge mclk_i);
      nrst_i <= 1'b0;
      subclock_present_i <= sub;
      repeat (4) @(posedge mclk_i);
      nrst_i <= 1'b1;
   endtask : rst
   task automatic go(input logic [3:0] k);
      @(posedge mclk_i);
      fire <= 1'b1;
      kind <= k;
      @(posedge mclk_i);
      fire <= 1'b0;
   endtask : go
   task automatic stop();
      bus(1'b1, `SMRC_OFS_PWR_CTRL, 32'h1);
      repeat (3) @(posedge mclk_i);
   endtask : stop
   task automatic wake(input int n, input logic [2:0] src);
      int c;
      c = 0;
      while (main_osc_en_o !== 1'b1) @(posedge mclk_i);
      while (cpu_clk_en_o !== 1'b1) begin
         @(posedge mclk_i);
         c++;
      end
      chk(32'(c >= (1 << n) && c <= (1 << n) + 3), 32'h1);
      while (wake_vector_o !== 1'b1) @(posedge mclk_i);
      chk(32'(wake_src_o), 32'(src));
      @(posedge mclk_i);
      chk(32'(wake_vector_o), 32'h0);
      chk(32'(port_hold_o), 32'h0);
   endtask : wake
   initial begin
      rst(1'b1);
      rd(`SMRC_OFS_SETTLE_SEL, 32'h6);
      rd(`SMRC_OFS_CLK_CFG, 32'h0);
      rd(`SMRC_OFS_WAKE_MASK, 32'hfff);
      rd(8'h14, 32'h0);
      bus(1'b1, `SMRC_OFS_STATUS, 32'hffffffff);
      rd(`SMRC_OFS_STATUS, 32'h3ffe0);
      chk(32'({sub_osc_en_o, wake_src_o, periph_run_o}), 32'h8fff);
      $display("test reset done");
      cpu_on_main_i <= 1'b0;
      stop();
      chk(32'(port_hold_o), 32'h0);
      cpu_on_main_i <= 1'b1;
      $display("test refused stop done");
      bus(1'b1, `SMRC_OFS_SETTLE_SEL, 32'h0);
      bus(1'b1, `SMRC_OFS_CLK_CFG, 32'h557);
      bus(1'b1, `SMRC_OFS_WAKE_MASK, 32'hffd);
      bus_hold_request_i <= 1'b1;
      ext_irq_group_high_i <= 3'h5;
      repeat (8) @(posedge mclk_i);
      chk(32'({bus_hold_ack_o, ext_irq_group_high_o}), 32'hd);
      stop();
      chk(32'({main_osc_en_o, cpu_clk_en_o, periph_clk_en_o, sub_osc_en_o}), 32'h1);
      chk(32'({port_hold_o, bus_float_o, bus_hold_ack_o, ext_irq_group_high_o}), 32'h30);
      chk(32'(periph_run_o), 32'h95b);
      rd(`SMRC_OFS_PWR_CTRL, 32'h1);
      go(4'h0);
      repeat (20) @(posedge mclk_i);
      chk(32'(port_hold_o), 32'h1);
      go(4'hf);
      go(4'hc);
      wake(2, SMRC_WK_NMI);
      repeat (3) @(posedge mclk_i);
      chk(32'({bus_hold_ack_o, periph_run_o}), 32'h1fff);
      $display("test nmi wake done");
      bus(1'b1, `SMRC_OFS_SETTLE_SEL, 32'h1);
      stop();
      go(4'h1);
      wake(3, SMRC_WK_PERIPH);
      $display("test peripheral wake done");
      stop();
      rst(1'b0);
      @(posedge mclk_i);
      chk(32'({cpu_clk_en_o, port_hold_o}), 32'h2);
      bus(1'b1, `SMRC_OFS_SETTLE_SEL, 32'h0);
      bus(1'b1, `SMRC_OFS_CLK_CFG, 32'h557);
      stop();
      chk(32'(periph_run_o), 32'h150);
      go(4'hd);
      wake(2, SMRC_WK_EXT);
      $display("test no subclock done");
      results();
   end
endmodule : tb_smrc_ctrl
